/* ceb_addr_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module ceb_addr_gen
(
  input  wire logic [35:0] i_base,
  input  wire logic [1:0]  i_beat,
  input  wire logic        i_subblock,
  output logic      [35:0] o_addr
);
  logic [1:0] word_idx;

  always_comb
  begin
    if (i_subblock)
      word_idx = i_base[4:3] ^ i_beat;
    else
      word_idx = i_base[4:3] + i_beat;
    o_addr = {i_base[35:5], word_idx, i_base[2:0]};
  end
endmodule
`default_nettype wire

/* ceb_bus_phases.sv */
`timescale 1ns/1ps
`default_nettype none
module ceb_bus_phases
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_irq,
  output logic             o_address_valid_out,
  output logic      [35:0] o_bus_address,
  input  wire logic        i_address_ready_in,
  output logic      [1:0]  o_burst_length_code,
  output logic             o_burst_phase_flag,
  output logic             o_instruction_fetch_flag,
  output logic             o_direction_is_store,
  input  wire logic        i_bus_clock_active_in,
  input  wire logic        i_ext_buffers_empty_in,
  input  wire logic        i_read_bus_error_in,
  input  wire logic [63:0] i_read_data_in,
  input  wire logic        i_read_data_valid_in,
  input  wire logic        i_subblock_order_select,
  input  wire logic        i_write_bus_error_in,
  output logic      [63:0] o_write_data_out,
  input  wire logic        i_write_data_ready_in
);
  ceb_pkg::ceb_state_t state_r;
  ceb_pkg::ceb_state_t state_nxt;
  logic [5:0]  ctrl_r;
  logic [5:0]  ctrl_nxt;
  logic [35:0] base_r;
  logic [35:0] base_nxt;
  logic [63:0] wbuf_r [4];
  logic [63:0] wbuf_nxt [4];
  logic [63:0] rbuf_r [4];
  logic [63:0] rbuf_nxt [4];
  logic [2:0]  acnt_r;
  logic [2:0]  acnt_nxt;
  logic [2:0]  dcnt_r;
  logic [2:0]  dcnt_nxt;
  logic        werr_pend_r;
  logic        werr_pend_nxt;
  logic        av_r;
  logic        av_nxt;
  logic [35:0] addr_r;
  logic [35:0] addr_nxt;
  logic [63:0] wdata_r;
  logic [63:0] wdata_nxt;
  logic [1:0]  blen_r;
  logic        burst_flag_r;
  logic        burst_flag_nxt;
  logic        instr_r;
  logic        instr_nxt;
  logic        store_r;
  logic        store_nxt;
  logic        waitreq_r;
  logic        waitreq_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [2:0]  events;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [35:0] gen_addr;
  logic [2:0]  beats;
  logic        accept;
  logic        data_ok;
  logic        rd_done;
  logic        wr_done;
  logic        wr_req;
  logic [31:0] wmask;
  logic [1:0]  idx;

  assign beats  = ctrl_r[ceb_pkg::CTRL_BURST] ? ceb_pkg::BEATS_BURST : ceb_pkg::BEATS_SINGLE;
  assign idx    = ctrl_r[ceb_pkg::CTRL_IDX_LO +: 2];
  assign wr_req = i_avs_write && !waitreq_r;
  assign wmask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // Next address of the burst comes from the count that will stand after this edge.
  ceb_addr_gen u_addr_gen
  (
    .i_base     (base_r),
    .i_beat     (acnt_nxt[1:0]),
    .i_subblock (i_subblock_order_select),
    .o_addr     (gen_addr)
  );

  // A data phase may end at the same edge that accepts its own address, never earlier.
  assign accept  = av_r && i_address_ready_in;
  assign data_ok = (state_r == ceb_pkg::ST_RUN) && (dcnt_r < beats) &&
                   ((dcnt_r < acnt_r) || (dcnt_r == acnt_r && accept));
  assign rd_done = data_ok && !store_r && i_read_data_valid_in;
  assign wr_done = data_ok && store_r && i_write_data_ready_in;

  always_comb
  begin
    state_nxt      = state_r;
    acnt_nxt       = acnt_r;
    dcnt_nxt       = dcnt_r;
    werr_pend_nxt  = wr_done;
    av_nxt         = av_r;
    addr_nxt       = addr_r;
    wdata_nxt      = wdata_r;
    burst_flag_nxt = burst_flag_r;
    instr_nxt      = instr_r;
    store_nxt      = store_r;
    rbuf_nxt       = rbuf_r;
    events         = 3'h0;
    unique case (state_r)
      ceb_pkg::ST_IDLE:
      begin
        if (wr_req && i_avs_address == ceb_pkg::OFS_CTRL &&
            i_avs_writedata[ceb_pkg::CTRL_START] && i_avs_byteenable[0])
        begin
          state_nxt      = ceb_pkg::ST_RUN;
          acnt_nxt       = 3'h0;
          dcnt_nxt       = 3'h0;
          av_nxt         = 1'b1;
          addr_nxt       = gen_addr;
          store_nxt      = i_avs_writedata[ceb_pkg::CTRL_STORE];
          instr_nxt      = i_avs_writedata[ceb_pkg::CTRL_INSTR] &&
                           !i_avs_writedata[ceb_pkg::CTRL_STORE];
          burst_flag_nxt = i_avs_writedata[ceb_pkg::CTRL_BURST];
          wdata_nxt      = wbuf_r[0];
        end
      end
      ceb_pkg::ST_RUN:
      begin
        if (accept)
        begin
          acnt_nxt = acnt_r + 3'h1;
          av_nxt   = (acnt_nxt < beats);
          addr_nxt = gen_addr;
        end
        if (rd_done)
        begin
          rbuf_nxt[dcnt_r[1:0]] = i_read_data_in;
          dcnt_nxt              = dcnt_r + 3'h1;
          events[ceb_pkg::EVT_RERR] = i_read_bus_error_in;
        end
        if (wr_done)
          dcnt_nxt = dcnt_r + 3'h1;
        // The far side takes the beat one edge after write ready, so the next beat
        // and the write error both wait for that edge.
        if (werr_pend_r)
        begin
          events[ceb_pkg::EVT_WERR] = i_write_bus_error_in;
          wdata_nxt = wbuf_r[dcnt_r[1:0]];
        end
        if (dcnt_r == beats && !werr_pend_r)
        begin
          state_nxt = ceb_pkg::ST_IDLE;
          events[ceb_pkg::EVT_DONE] = 1'b1;
        end
      end
    endcase
  end

  // Register file; a started transfer cannot have its buffers rewritten under it.
  always_comb
  begin
    ctrl_nxt    = ctrl_r;
    base_nxt    = base_r;
    wbuf_nxt    = wbuf_r;
    waitreq_nxt = !((i_avs_read || i_avs_write) && waitreq_r);
    rdata_nxt   = rdata_r;
    ctrl_nxt[ceb_pkg::CTRL_START] = (state_r == ceb_pkg::ST_RUN);
    if (wr_req && state_r == ceb_pkg::ST_IDLE)
    begin
      unique case (i_avs_address)
        ceb_pkg::OFS_CTRL:
          ctrl_nxt[5:1] = (ctrl_r[5:1] & ~wmask[5:1]) | (i_avs_writedata[5:1] & wmask[5:1]);
        ceb_pkg::OFS_ADDR_LO:
          base_nxt[31:0] = (base_r[31:0] & ~wmask) | (i_avs_writedata & wmask);
        ceb_pkg::OFS_ADDR_HI:
          base_nxt[35:32] = (base_r[35:32] & ~wmask[3:0]) | (i_avs_writedata[3:0] & wmask[3:0]);
        ceb_pkg::OFS_WD_LO:
          wbuf_nxt[idx][31:0] = (wbuf_r[idx][31:0] & ~wmask) | (i_avs_writedata & wmask);
        ceb_pkg::OFS_WD_HI:
          wbuf_nxt[idx][63:32] = (wbuf_r[idx][63:32] & ~wmask) | (i_avs_writedata & wmask);
        default:
          ctrl_nxt = ctrl_nxt;
      endcase
    end
    if (i_avs_read && waitreq_r)
    begin
      unique case (i_avs_address)
        ceb_pkg::OFS_CTRL:    rdata_nxt = {26'h0, ctrl_r};
        ceb_pkg::OFS_ADDR_LO: rdata_nxt = base_r[31:0];
        ceb_pkg::OFS_ADDR_HI: rdata_nxt = {28'h0, base_r[35:32]};
        ceb_pkg::OFS_STATUS:  rdata_nxt = {25'h0, dcnt_r, i_subblock_order_select,
                                           i_bus_clock_active_in, i_ext_buffers_empty_in,
                                           state_r == ceb_pkg::ST_RUN};
        ceb_pkg::OFS_IRQ_ST:  rdata_nxt = {29'h0, irq_status};
        ceb_pkg::OFS_IRQ_MSK: rdata_nxt = {29'h0, irq_mask};
        ceb_pkg::OFS_WD_LO:   rdata_nxt = wbuf_r[idx][31:0];
        ceb_pkg::OFS_WD_HI:   rdata_nxt = wbuf_r[idx][63:32];
        ceb_pkg::OFS_RD_LO:   rdata_nxt = rbuf_r[idx][31:0];
        ceb_pkg::OFS_RD_HI:   rdata_nxt = rbuf_r[idx][63:32];
        default:              rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_r      <= ceb_pkg::ST_IDLE;
      ctrl_r       <= ceb_pkg::CTRL_RST;
      base_r       <= 36'h0;
      wbuf_r       <= '{default: 64'h0};
      rbuf_r       <= '{default: 64'h0};
      acnt_r       <= 3'h0;
      dcnt_r       <= 3'h0;
      werr_pend_r  <= 1'b0;
      av_r         <= 1'b0;
      addr_r       <= 36'h0;
      wdata_r      <= 64'h0;
      blen_r       <= ceb_pkg::BLEN_FOUR;
      burst_flag_r <= 1'b0;
      instr_r      <= 1'b0;
      store_r      <= 1'b0;
      waitreq_r    <= 1'b1;
      rdata_r      <= 32'h0;
    end
    else
    begin
      state_r      <= state_nxt;
      ctrl_r       <= ctrl_nxt;
      base_r       <= base_nxt;
      wbuf_r       <= wbuf_nxt;
      rbuf_r       <= rbuf_nxt;
      acnt_r       <= acnt_nxt;
      dcnt_r       <= dcnt_nxt;
      werr_pend_r  <= werr_pend_nxt;
      av_r         <= av_nxt;
      addr_r       <= addr_nxt;
      wdata_r      <= wdata_nxt;
      blen_r       <= ceb_pkg::BLEN_FOUR;
      burst_flag_r <= burst_flag_nxt;
      instr_r      <= instr_nxt;
      store_r      <= store_nxt;
      waitreq_r    <= waitreq_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  ceb_irq u_irq
  (
    .i_core_clk     (i_core_clk),
    .i_rst          (i_rst),
    .i_event        (events),
    .i_status_clear (i_avs_read && waitreq_r && i_avs_address == ceb_pkg::OFS_IRQ_ST),
    .i_mask_we      (wr_req && i_avs_address == ceb_pkg::OFS_IRQ_MSK && i_avs_byteenable[0]),
    .i_mask_wdata   (i_avs_writedata[2:0]),
    .o_status       (irq_status),
    .o_mask         (irq_mask),
    .o_irq          (o_irq)
  );

  assign o_avs_readdata           = rdata_r;
  assign o_avs_waitrequest        = waitreq_r;
  assign o_address_valid_out      = av_r;
  assign o_bus_address            = addr_r;
  assign o_burst_length_code      = blen_r;
  assign o_burst_phase_flag       = burst_flag_r;
  assign o_instruction_fetch_flag = instr_r;
  assign o_direction_is_store     = store_r;
  assign o_write_data_out         = wdata_r;

  // Helper: beat index of the last read capture.
  logic [1:0] cap_idx_r;
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      cap_idx_r <= 2'h0;
    else if (rd_done)
      cap_idx_r <= dcnt_r[1:0];
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  blen_static_a: assert property (o_burst_length_code == ceb_pkg::BLEN_FOUR)
    else $error("burst length code not four-phase");
  burst_flag_a: assert property (o_address_valid_out |->
    o_burst_phase_flag == (beats == ceb_pkg::BEATS_BURST))
    else $error("burst flag disagrees with burst size");
  instr_read_a: assert property (o_address_valid_out && o_instruction_fetch_flag |->
    !o_direction_is_store)
    else $error("instruction fetch marked as write");
  rdata_cap_a: assert property (rd_done |=> rbuf_r[cap_idx_r] == $past(i_read_data_in))
    else $error("read data not captured");
  order_a: assert property (o_address_valid_out && o_burst_phase_flag |->
    o_bus_address[4:3] == (i_subblock_order_select ? base_r[4:3] ^ acnt_r[1:0]
                                                   : base_r[4:3] + acnt_r[1:0]))
    else $error("burst address order wrong");
  wdata_hold_a: assert property (state_r == ceb_pkg::ST_RUN && o_direction_is_store &&
    !werr_pend_r |=> $stable(o_write_data_out))
    else $error("write data moved during data phase");
  data_after_addr_a: assert property (dcnt_r <= acnt_r)
    else $error("data phase ended before its address");
  dir_a: assert property (o_address_valid_out |->
    o_direction_is_store == ctrl_r[ceb_pkg::CTRL_STORE])
    else $error("direction flag wrong");
  accept_a: assert property (o_address_valid_out && i_address_ready_in |=>
    acnt_r == $past(acnt_r) + 3'h1)
    else $error("address acceptance not counted");

  read_burst_c: cover property (rd_done && dcnt_r == 3'h3);
  write_burst_c: cover property (wr_done && dcnt_r == 3'h3);
  error_c: cover property (events[ceb_pkg::EVT_WERR] || events[ceb_pkg::EVT_RERR]);
endmodule
`default_nettype wire

/* ceb_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ceb_ext_model
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_address_valid_out,
  input  wire logic [35:0] i_bus_address,
  input  wire logic        i_direction_is_store,
  input  wire logic [1:0]  i_wait,
  input  wire logic        i_rerr_en,
  input  wire logic        i_werr_en,
  output logic             o_address_ready_in,
  output logic             o_read_data_valid_in,
  output logic      [63:0] o_read_data_in,
  output logic             o_read_bus_error_in,
  output logic             o_write_data_ready_in,
  output logic             o_write_bus_error_in,
  output logic             o_ext_buffers_empty_in,
  output logic             o_bus_clock_active_in
);
  logic [36:0] pend_q[$];
  logic [1:0]  acnt;
  logic [1:0]  dcnt;
  logic [1:0]  drain;
  logic        acc;
  logic        done;
  logic        rv;
  logic        wr;

  assign o_bus_clock_active_in = 1'b1;

  // A phase is queued at its accepting edge, so its data phase can only follow that edge.
  always @(posedge i_core_clk)
  begin
    acc  = i_address_valid_out && o_address_ready_in;
    done = o_read_data_valid_in || o_write_data_ready_in;
    rv   = 1'b0;
    wr   = 1'b0;
    if (i_rst)
    begin
      pend_q.delete();
      acnt                   <= 2'h0;
      dcnt                   <= 2'h0;
      drain                  <= 2'h0;
      o_address_ready_in     <= 1'b0;
      o_read_data_in         <= 64'h0;
      o_ext_buffers_empty_in <= 1'b1;
    end
    else
    begin
      if (done)
        void'(pend_q.pop_front());
      if (acc)
        pend_q.push_back({i_direction_is_store, i_bus_address});
      if (done)
        dcnt <= 2'h0;
      else if (pend_q.size() > 0)
      begin
        if (dcnt >= i_wait)
        begin
          wr = pend_q[0][36];
          rv = !pend_q[0][36];
        end
        else
          dcnt <= dcnt + 2'h1;
      end
      acnt <= (acc || !i_address_valid_out) ? 2'h0 : ((acnt == 2'h3) ? acnt : acnt + 2'h1);
      o_address_ready_in <= i_address_valid_out && !acc && (acnt >= i_wait);
      // Outside a data phase the bus shows the inverse of its last value, never a stale copy.
      o_read_data_in <= rv ? {pend_q[0][31:0], ~pend_q[0][31:0]} : ~o_read_data_in;
      if (o_write_data_ready_in)
      begin
        drain                  <= 2'h3;
        o_ext_buffers_empty_in <= 1'b0;
      end
      else if (drain != 2'h0)
        drain <= drain - 2'h1;
      else
        o_ext_buffers_empty_in <= 1'b1;
    end
    o_read_data_valid_in  <= rv;
    o_write_data_ready_in <= wr;
    o_read_bus_error_in   <= rv && i_rerr_en;
    o_write_bus_error_in  <= o_write_data_ready_in && i_werr_en && !i_rst;
  end
endmodule
`default_nettype wire

/* ceb_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module ceb_irq
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_event,
  input  wire logic       i_status_clear,
  input  wire logic       i_mask_we,
  input  wire logic [2:0] i_mask_wdata,
  output logic      [2:0] o_status,
  output logic      [2:0] o_mask,
  output logic            o_irq
);
  logic [2:0] status_r;
  logic [2:0] status_nxt;
  logic [2:0] mask_r;
  logic [2:0] mask_nxt;
  logic       irq_r;
  logic       irq_nxt;

  // An event arriving in the clearing cycle survives the clear.
  always_comb
  begin
    status_nxt = (i_status_clear ? 3'h0 : status_r) | i_event;
    mask_nxt   = i_mask_we ? i_mask_wdata : mask_r;
    irq_nxt    = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      status_r <= 3'h0;
      mask_r   <= ceb_pkg::MASK_RST;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign o_status = status_r;
  assign o_mask   = mask_r;
  assign o_irq    = irq_r;
endmodule
`default_nettype wire

/* ceb_pkg.sv */
package ceb_pkg;

  localparam int unsigned ADDR_W    = 36;
  localparam int unsigned DATA_W    = 64;
  localparam int unsigned BEAT_W    = 3;
  localparam int unsigned EVT_W     = 3;

  // Burst length code: only the four-phase encoding is defined.
  localparam logic [1:0]  BLEN_FOUR = 2'h1;
  localparam logic [2:0]  BEATS_BURST  = 3'h4;
  localparam logic [2:0]  BEATS_SINGLE = 3'h1;

  // Avalon byte offsets.
  localparam logic [5:0]  OFS_CTRL    = 6'h00;
  localparam logic [5:0]  OFS_ADDR_LO = 6'h04;
  localparam logic [5:0]  OFS_ADDR_HI = 6'h08;
  localparam logic [5:0]  OFS_STATUS  = 6'h0c;
  localparam logic [5:0]  OFS_IRQ_ST  = 6'h10;
  localparam logic [5:0]  OFS_IRQ_MSK = 6'h14;
  localparam logic [5:0]  OFS_WD_LO   = 6'h18;
  localparam logic [5:0]  OFS_WD_HI   = 6'h1c;
  localparam logic [5:0]  OFS_RD_LO   = 6'h20;
  localparam logic [5:0]  OFS_RD_HI   = 6'h24;

  // Control register fields.
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_STORE = 1;
  localparam int unsigned CTRL_INSTR = 2;
  localparam int unsigned CTRL_BURST = 3;
  localparam int unsigned CTRL_IDX_LO = 4;

  // Event bits, shared by the status and mask registers.
  localparam int unsigned EVT_DONE = 0;
  localparam int unsigned EVT_RERR = 1;
  localparam int unsigned EVT_WERR = 2;

  localparam logic [5:0]  CTRL_RST = 6'h00;
  localparam logic [2:0]  MASK_RST = 3'h0;

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} ceb_state_t;

endpackage

/* test_ceb_bus_phases.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ceb_bus_phases;
  logic        core_clk;
  logic        rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        addr_valid;
  logic [35:0] bus_addr;
  logic        addr_rdy;
  logic [1:0]  blen;
  logic        burst_flag;
  logic        instr_flag;
  logic        dir_store;
  logic        clk_active;
  logic        buf_empty;
  logic        rerr;
  logic [63:0] rdata;
  logic        rdval;
  logic        sub_sel;
  logic        werr;
  logic [63:0] wdata;
  logic        wdrdy;
  logic [1:0]  wait_cyc;
  logic        rerr_en;
  logic        werr_en;
  logic [35:0] exp_addr[4];
  logic [63:0] exp_wd[4];
  logic        exp_st;
  logic        exp_in;
  logic        exp_bu;
  logic [31:0] v;
  logic [31:0] q;
  logic        wd_seen;
  int          seed;
  int          n_acc;
  int          n_wd;
  int          err_count;
  int          n_checks;

  ceb_bus_phases i_ceb_bus_phases (.i_core_clk(core_clk), .i_rst(rst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .o_irq(irq), .o_address_valid_out(addr_valid),
    .o_bus_address(bus_addr), .i_address_ready_in(addr_rdy), .o_burst_length_code(blen),
    .o_burst_phase_flag(burst_flag), .o_instruction_fetch_flag(instr_flag),
    .o_direction_is_store(dir_store), .i_bus_clock_active_in(clk_active),
    .i_ext_buffers_empty_in(buf_empty), .i_read_bus_error_in(rerr), .i_read_data_in(rdata),
    .i_read_data_valid_in(rdval), .i_subblock_order_select(sub_sel),
    .i_write_bus_error_in(werr), .o_write_data_out(wdata), .i_write_data_ready_in(wdrdy));

  ceb_ext_model i_ceb_ext_model (.i_core_clk(core_clk), .i_rst(rst),
    .i_address_valid_out(addr_valid), .i_bus_address(bus_addr),
    .i_direction_is_store(dir_store), .i_wait(wait_cyc), .i_rerr_en(rerr_en),
    .i_werr_en(werr_en), .o_address_ready_in(addr_rdy), .o_read_data_valid_in(rdval),
    .o_read_data_in(rdata), .o_read_bus_error_in(rerr), .o_write_data_ready_in(wdrdy),
    .o_write_bus_error_in(werr), .o_ext_buffers_empty_in(buf_empty),
    .o_bus_clock_active_in(clk_active));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [63:0] rd_of(input logic [35:0] a);
    return {a[31:0], ~a[31:0]};
  endfunction

  // One idle edge before each request keeps a driver from assigning a strobe twice in a step.
  task automatic av_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                         output logic [31:0] rq);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    av_xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] rq);
    av_xfer(1'b0, a, 32'h0, rq);
  endtask

  always @(posedge core_clk)
  begin
    if (!rst && addr_valid && addr_rdy && n_acc < 4)
    begin
      check("addr", bus_addr, exp_addr[n_acc]);
      check("dir", dir_store, exp_st);
      check("instr", instr_flag, exp_in & ~exp_st);
      check("burst", burst_flag, exp_bu);
      check("blen", blen, ceb_pkg::BLEN_FOUR);
      n_acc++;
    end
    // Write data is checked at the edge after write ready, where the far side takes it.
    if (!rst && wd_seen && n_wd < 4)
    begin
      check("wdata", wdata, exp_wd[n_wd]);
      n_wd++;
    end
    wd_seen <= wdrdy && !rst;
  end

  task automatic run_xfer(input logic st, input logic in_, input logic bu, input logic sb,
                          input logic [35:0] base, input logic re, input logic we,
                          input logic [2:0] mk, input logic [1:0] wt);
    logic [31:0] rq;
    logic [31:0] sts;
    logic [2:0]  ev;
    int          nb;
    nb = bu ? 4 : 1;
    for (int k = 0; k < 4; k++)
    begin
      exp_addr[k] = {base[35:5], sb ? base[4:3] ^ k[1:0] : base[4:3] + k[1:0], base[2:0]};
      exp_wd[k]   = {$random(seed), $random(seed)};
    end
    exp_st = st;
    exp_in = in_;
    exp_bu = bu;
    sub_sel  <= sb;
    rerr_en  <= re;
    werr_en  <= we;
    wait_cyc <= wt;
    wr(ceb_pkg::OFS_IRQ_MSK, {29'h0, mk});
    wr(ceb_pkg::OFS_ADDR_LO, base[31:0]);
    wr(ceb_pkg::OFS_ADDR_HI, {28'h0, base[35:32]});
    for (int k = 0; k < nb && st; k++)
    begin
      wr(ceb_pkg::OFS_CTRL, {26'h0, k[1:0], 4'h0});
      wr(ceb_pkg::OFS_WD_LO, exp_wd[k][31:0]);
      wr(ceb_pkg::OFS_WD_HI, exp_wd[k][63:32]);
    end
    n_acc = 0;
    n_wd  = 0;
    wr(ceb_pkg::OFS_CTRL, {26'h0, 2'h0, bu, in_, st, 1'b1});
    wr(ceb_pkg::OFS_ADDR_LO, ~base[31:0]);
    for (int i = 0; i < 100; i++)
    begin
      rd(ceb_pkg::OFS_STATUS, sts);
      if (sts[0] === 1'b0)
        break;
    end
    rd(ceb_pkg::OFS_ADDR_LO, rq);
    check("addr kept", rq, base[31:0]);
    check("beats", n_acc, nb);
    check("wbeats", n_wd, st ? nb : 0);
    check("order", sts[3], sb);
    check("done cnt", sts[6:4], nb);
    ev = {we & st, re & ~st, 1'b1};
    repeat (2) @(posedge core_clk);
    check("irq", irq, |(ev & mk));
    rd(ceb_pkg::OFS_IRQ_ST, rq);
    check("events", rq[2:0], ev);
    rd(ceb_pkg::OFS_IRQ_ST, rq);
    check("cleared", rq[2:0], 3'h0);
    check("irq off", irq, 1'b0);
    rd(ceb_pkg::OFS_STATUS, sts);
    check("empty act", sts[2:1], 2'h3);
    for (int k = 0; k < nb && !st; k++)
    begin
      wr(ceb_pkg::OFS_CTRL, {26'h0, k[1:0], 4'h0});
      rd(ceb_pkg::OFS_RD_LO, rq);
      check("rdata lo", rq, rd_of(exp_addr[k]) & 64'hffff_ffff);
      rd(ceb_pkg::OFS_RD_HI, rq);
      check("rdata hi", rq, rd_of(exp_addr[k]) >> 32);
    end
  endtask

  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    conclude();
  end

  initial
  begin
    seed = 72;
    err_count = 0;
    n_checks = 0;
    n_acc = 0;
    n_wd = 0;
    rst = 1'b1;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    sub_sel = 1'b0;
    wait_cyc = 2'h0;
    rerr_en = 1'b0;
    werr_en = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check("wait rst", avs_waitrequest, 1'b1);
    check("blen rst", blen, ceb_pkg::BLEN_FOUR);
    check("valid rst", addr_valid, 1'b0);
    rd(6'h3c, q);
    check("unmapped", q, 32'h0);
    run_xfer(1'b0, 1'b1, 1'b1, 1'b1, 36'h9_1234_5678, 1'b0, 1'b0, 3'h7, 2'h3);
    run_xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h9_1234_5678, 1'b0, 1'b1, 3'h4, 2'h0);
    run_xfer(1'b0, 1'b0, 1'b0, 1'b1, 36'h0_0000_0ff8, 1'b1, 1'b0, 3'h2, 2'h1);
    for (int t = 0; t < 16; t++)
    begin
      v = $random(seed);
      run_xfer(v[0], v[1], v[2], v[3], {v[7:4], $random(seed)} & 36'hf_ffff_fff8,
               v[8], v[9], v[12:10], v[14:13]);
    end
    conclude();
  end
endmodule
`default_nettype wire
